// *** shared/gpio_event_pkg.sv ***
// Constants shared by the port and event detector block.
// Assumes one 250 MHz bus clock and a 32-bit Avalon-MM register bus.
package gpio_event_pkg;

  localparam int PIN_COUNT = 16;
  localparam int LINE_COUNT = 20;
  localparam int PORT_COUNT = 4;
  localparam int SYNC_WIDTH = 68;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE0 = 8'h00;
  localparam logic [7:0] OFS_MODE1 = 8'h04;
  localparam logic [7:0] OFS_MODE2 = 8'h08;
  localparam logic [7:0] OFS_MODE3 = 8'h0C;
  localparam logic [7:0] OFS_INPUT = 8'h10;
  localparam logic [7:0] OFS_OUTPUT = 8'h14;
  localparam logic [7:0] OFS_SET_RESET = 8'h18;
  localparam logic [7:0] OFS_LOCK = 8'h1C;
  localparam logic [7:0] OFS_INT_MASK = 8'h20;
  localparam logic [7:0] OFS_EVT_MASK = 8'h24;
  localparam logic [7:0] OFS_RISE = 8'h28;
  localparam logic [7:0] OFS_FALL = 8'h2C;
  localparam logic [7:0] OFS_SW_TRIG = 8'h30;
  localparam logic [7:0] OFS_PENDING = 8'h34;
  localparam logic [7:0] OFS_SOURCE_SEL = 8'h38;

  // Pin mode codes, one byte per pin
  localparam logic [7:0] ANALOG_INPUT_CODE = 8'h00;
  localparam logic [7:0] FLOATING_INPUT_CODE = 8'h04;
  localparam logic [7:0] PULLDOWN_INPUT_CODE = 8'h28;
  localparam logic [7:0] PULLUP_INPUT_CODE = 8'h48;
  localparam logic [7:0] OPENDRAIN_OUTPUT_CODE = 8'h14;
  localparam logic [7:0] PUSHPULL_OUTPUT_CODE = 8'h10;
  localparam logic [7:0] ALT_OPENDRAIN_CODE = 8'h1C;
  localparam logic [7:0] ALT_PUSHPULL_CODE = 8'h18;

  // Reset values
  localparam logic [7:0] RST_MODE = 8'h04;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage

// *** hdl/gpio_event_port.sv ***
// Sixteen-pin general purpose port with a twenty-line edge event detector.
// Assumes pad inputs and internal wake lines are asynchronous to CLK and
// a single Avalon-MM master with waitrequest on the register side.
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1: Input pad level is captured into input data every clock.
// RL2: Input modes keep the pin output driver off.
// RL3: Input mode selects pull-up, pull-down or floating.
// RL4: Output modes force both pull resistors off.
// RL5: Input sampling stays active in every mode.
// RL6: Open-drain: bit 0 drives low, bit 1 releases the pin.
// RL7: Push-pull: bit 0 drives low, bit 1 drives high.
// RL8: Output data reads back the value last written.
// RL9: Input data returns the real pad level, even in open-drain.
// RL10: Eight pin modes with their fixed configuration codes.
// RL11: Separate set and reset bits per output pin.
// RL12: Lock bits freeze a pin's mode against later writes.
// RL13: Twenty independent edge detectors raise interrupts or events.
// RL14: Each detector triggers on rising, falling or both edges.
// RL15: Every detector has its own configuration and mask.
// RL16: Sixteen pin lines plus four internal wake lines.
// RL17: Source select picks which port drives each pin line.
// RL18: Software can trigger a line directly.
// RL19: Each line has an interrupt output and a separate event output.
// RL20: Unmasked edge sets pending until software writes one to clear.
// RL21: Edges found by comparing synchronised level with previous cycle.
module gpio_event_port
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Avalon-MM slave
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // Pins
  input wire logic [gpio_event_pkg::PIN_COUNT-1:0] PAD_IN,
  output logic [gpio_event_pkg::PIN_COUNT-1:0] PAD_OUT,
  output logic [gpio_event_pkg::PIN_COUNT-1:0] PAD_OE,
  output logic [gpio_event_pkg::PIN_COUNT-1:0] PULL_UP_EN,
  output logic [gpio_event_pkg::PIN_COUNT-1:0] PULL_DOWN_EN,
  // Alternate peripheral drive
  input wire logic [gpio_event_pkg::PIN_COUNT-1:0] ALT_OUT,
  // Other ports as event sources, port 1 in the low bits
  input wire logic [47:0] OTHER_PORT_IN,
  // Internal wake lines
  input wire logic LOW_VOLTAGE_DETECT,
  input wire logic CALENDAR_ALARM,
  input wire logic SERIAL_BUS_WAKE,
  input wire logic NETWORK_WAKE,
  // Towards the processor
  output logic [gpio_event_pkg::LINE_COUNT-1:0] IRQ,
  output logic [gpio_event_pkg::LINE_COUNT-1:0] EVENT
);
  import gpio_event_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [SYNC_WIDTH-1:0] raw_in;
  logic [SYNC_WIDTH-1:0] sync_meta;
  logic [SYNC_WIDTH-1:0] sync_level;
  logic [PIN_COUNT-1:0] in_data;
  logic [PIN_COUNT-1:0] out_data;
  logic [PIN_COUNT-1:0] lock;
  logic [7:0] pin_mode [PIN_COUNT];
  logic [LINE_COUNT-1:0] int_mask;
  logic [LINE_COUNT-1:0] evt_mask;
  logic [LINE_COUNT-1:0] rise_en;
  logic [LINE_COUNT-1:0] fall_en;
  logic [LINE_COUNT-1:0] sw_pulse;
  logic [LINE_COUNT-1:0] pending;
  logic [LINE_COUNT-1:0] line_level;
  logic [LINE_COUNT-1:0] line_prev;
  logic [LINE_COUNT-1:0] trig;
  logic [LINE_COUNT-1:0] next_pending;
  logic [31:0] source_sel;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [PIN_COUNT-1:0] next_out;
  logic [PIN_COUNT-1:0] next_oe;
  logic [PIN_COUNT-1:0] next_pu;
  logic [PIN_COUNT-1:0] next_pd;
  logic wr_take;
  logic req_take;

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then a single accepting cycle
  assign wr_take = WRITE & ~WAITREQUEST;
  assign req_take = (READ | WRITE) & WAITREQUEST;
  assign wmask = {{8{BYTEENABLE[3]}}, {8{BYTEENABLE[2]}},
                  {8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      WAITREQUEST <= 1'b1;
    else if (req_take)
      WAITREQUEST <= 1'b0;
    else
      WAITREQUEST <= 1'b1;
  end

  always_comb
  begin
    rd_mux = RST_WORD;
    case (ADDRESS)
      OFS_MODE0: rd_mux = {pin_mode[3], pin_mode[2], pin_mode[1], pin_mode[0]};
      OFS_MODE1: rd_mux = {pin_mode[7], pin_mode[6], pin_mode[5], pin_mode[4]};
      OFS_MODE2: rd_mux = {pin_mode[11], pin_mode[10], pin_mode[9], pin_mode[8]};
      OFS_MODE3: rd_mux = {pin_mode[15], pin_mode[14], pin_mode[13], pin_mode[12]};
      OFS_INPUT: rd_mux = {16'h0000, in_data}; // RL9
      OFS_OUTPUT: rd_mux = {16'h0000, out_data}; // RL8
      OFS_LOCK: rd_mux = {16'h0000, lock};
      OFS_INT_MASK: rd_mux = {12'h000, int_mask};
      OFS_EVT_MASK: rd_mux = {12'h000, evt_mask};
      OFS_RISE: rd_mux = {12'h000, rise_en};
      OFS_FALL: rd_mux = {12'h000, fall_en};
      OFS_PENDING: rd_mux = {12'h000, pending};
      OFS_SOURCE_SEL: rd_mux = source_sel;
      default: rd_mux = RST_WORD;
    endcase
  end

  // Read data is loaded with the wait cycle so it stands when waitrequest drops
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      READDATA <= RST_WORD;
    else if (READ && req_take)
      READDATA <= rd_mux;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin configuration
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      for (int i = 0; i < PIN_COUNT; i++)
        pin_mode[i] <= RST_MODE;
    end
    else if (wr_take && ADDRESS[7:4] == OFS_MODE0[7:4])
    begin
      // Byte lane k of mode word r belongs to pin 4r+k
      for (int k = 0; k < 4; k++)
      begin
        if (BYTEENABLE[k] && !lock[{ADDRESS[3:2], k[1:0]}]) // RL12
          pin_mode[{ADDRESS[3:2], k[1:0]}] <= WRITEDATA[8*k +: 8];
      end
    end
  end

  // Lock bits only set; a reset is the only way to unfreeze a pin
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      lock <= RST_WORD[PIN_COUNT-1:0];
    else if (wr_take && ADDRESS == OFS_LOCK)
      lock <= lock | (WRITEDATA[PIN_COUNT-1:0] & wmask[PIN_COUNT-1:0]); // RL12
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      out_data <= RST_WORD[PIN_COUNT-1:0];
    else if (wr_take && ADDRESS == OFS_OUTPUT)
      out_data <= (out_data & ~wmask[PIN_COUNT-1:0])
                | (WRITEDATA[PIN_COUNT-1:0] & wmask[PIN_COUNT-1:0]);
    else if (wr_take && ADDRESS == OFS_SET_RESET)
      // Set wins over reset when both bits of a pin are written
      out_data <= (out_data & ~(WRITEDATA[31:16] & wmask[31:16]))
                | (WRITEDATA[15:0] & wmask[15:0]); // RL11
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pad drivers and pulls
  always_comb
  begin
    next_out = '0;
    next_oe = '0;
    next_pu = '0;
    next_pd = '0;
    for (int i = 0; i < PIN_COUNT; i++)
    begin
      case (pin_mode[i]) // RL10
        PUSHPULL_OUTPUT_CODE:
        begin
          next_oe[i] = 1'b1; // RL7
          next_out[i] = out_data[i];
        end
        ALT_PUSHPULL_CODE:
        begin
          next_oe[i] = 1'b1;
          next_out[i] = ALT_OUT[i];
        end
        OPENDRAIN_OUTPUT_CODE:
          next_oe[i] = ~out_data[i]; // RL6
        ALT_OPENDRAIN_CODE:
          next_oe[i] = ~ALT_OUT[i];
        PULLUP_INPUT_CODE:
          next_pu[i] = 1'b1; // RL3
        PULLDOWN_INPUT_CODE:
          next_pd[i] = 1'b1;
        // Analog, floating and unknown codes leave the pin undriven
        default:
          next_oe[i] = 1'b0; // RL2
      endcase
    end
  end

  // Output modes fall to the default pull value of zero
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PAD_OUT <= '0;
      PAD_OE <= '0;
      PULL_UP_EN <= '0;
      PULL_DOWN_EN <= '0;
    end
    else
    begin
      PAD_OUT <= next_out;
      PAD_OE <= next_oe; // RL2
      PULL_UP_EN <= next_pu; // RL4
      PULL_DOWN_EN <= next_pd; // RL4
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input sampling, independent of mode
  assign raw_in = {NETWORK_WAKE, SERIAL_BUS_WAKE, CALENDAR_ALARM, LOW_VOLTAGE_DETECT,
                   OTHER_PORT_IN, PAD_IN};

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync_meta <= '0;
      sync_level <= '0;
    end
    else
    begin
      sync_meta <= raw_in;
      sync_level <= sync_meta;
    end
  end

  // Analog mode still samples; software simply ignores that bit
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      in_data <= '0;
    else
      in_data <= sync_level[PIN_COUNT-1:0]; // RL1 RL5
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event detector configuration
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      int_mask <= '0;
      evt_mask <= '0;
      rise_en <= '0;
      fall_en <= '0;
      source_sel <= RST_WORD;
    end
    else if (wr_take)
    begin
      case (ADDRESS) // RL15
        OFS_INT_MASK: int_mask <= (int_mask & ~wmask[19:0]) | (WRITEDATA[19:0] & wmask[19:0]);
        OFS_EVT_MASK: evt_mask <= (evt_mask & ~wmask[19:0]) | (WRITEDATA[19:0] & wmask[19:0]);
        OFS_RISE: rise_en <= (rise_en & ~wmask[19:0]) | (WRITEDATA[19:0] & wmask[19:0]);
        OFS_FALL: fall_en <= (fall_en & ~wmask[19:0]) | (WRITEDATA[19:0] & wmask[19:0]);
        OFS_SOURCE_SEL: source_sel <= (source_sel & ~wmask) | (WRITEDATA & wmask);
        default: source_sel <= source_sel;
      endcase
    end
  end

  // Software trigger is a one-cycle pulse; the register reads as zero
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      sw_pulse <= '0;
    else if (wr_take && ADDRESS == OFS_SW_TRIG)
      sw_pulse <= WRITEDATA[19:0] & wmask[19:0]; // RL18
    else
      sw_pulse <= '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Line sources and edge detection
  always_comb
  begin
    line_level = '0;
    for (int n = 0; n < PIN_COUNT; n++)
      line_level[n] = sync_level[PIN_COUNT * int'(source_sel[2*n +: 2]) + n]; // RL17
    line_level[19:16] = sync_level[67:64]; // RL16
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      line_prev <= '0;
    else
      line_prev <= line_level;
  end

  // A source switch can look like an edge; change selection with the line masked
  assign trig = (line_level & ~line_prev & rise_en)
              | (~line_level & line_prev & fall_en)
              | sw_pulse; // RL13 RL14 RL21

  // A new edge in the clearing cycle keeps the flag set
  assign next_pending = (wr_take && ADDRESS == OFS_PENDING)
                      ? ((pending & ~(WRITEDATA[19:0] & wmask[19:0])) | (trig & int_mask))
                      : (pending | (trig & int_mask));

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      pending <= '0;
    else
      pending <= next_pending; // RL20
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      IRQ <= '0;
      EVENT <= '0;
    end
    else
    begin
      IRQ <= next_pending & int_mask; // RL19
      EVENT <= trig & evt_mask; // RL19
    end
  end

endmodule // gpio_event_port

// *** verification/pin_partner.sv ***
// Far-side pin model: resolves each pad from port drive, a far driver and pulls.
// Assumes one clock; an undriven pin without pull flips every cycle.
`timescale 1ns/100ps
module pin_partner
(
  // Clock
  input wire logic clk,
  // Port side
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] pull_up_en,
  input wire logic [15:0] pull_down_en,
  // Far driver
  input wire logic [15:0] ext_val,
  input wire logic [15:0] ext_en,
  // Resolved pad level
  output logic [15:0] level
);
  logic [15:0] flt = 16'h0000;

  // Flipping pattern so a floating pin never reads as a held value
  always @(posedge clk)
    flt <= ~flt;

  always_comb
    for (int i = 0; i < 16; i++)
      level[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                 pull_up_en[i] | (~pull_down_en[i] & flt[i]);
endmodule // pin_partner

// *** verification/gpio_event_sva.sv ***
// Checker for the port: bus handshake, pull and event output relations.
// Assumes full-word writes to the mask registers.
`timescale 1ns/100ps
module gpio_event_sva
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Bus
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic WAITREQUEST,
  // Pins
  input wire logic [gpio_event_pkg::PIN_COUNT-1:0] PAD_OE,
  input wire logic [gpio_event_pkg::PIN_COUNT-1:0] PULL_UP_EN,
  input wire logic [gpio_event_pkg::PIN_COUNT-1:0] PULL_DOWN_EN,
  // Processor side
  input wire logic [gpio_event_pkg::LINE_COUNT-1:0] IRQ,
  input wire logic [gpio_event_pkg::LINE_COUNT-1:0] EVENT
);
  import gpio_event_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic req;
  logic acc;
  logic clr;
  logic [19:0] imask;
  logic [19:0] emask;
  logic [19:0] ti;
  logic [19:0] tw;
  assign req = READ || WRITE;
  assign acc = WRITE && !WAITREQUEST;
  assign clr = acc && (ADDRESS == OFS_PENDING || ADDRESS == OFS_INT_MASK);
  assign ti = WRITEDATA[19:0] & imask;
  assign tw = WRITEDATA[19:0] & emask;

  ////////////////////////////////////////////////////////////////////////////
  // Shadow masks, so trigger checks know which lines must answer
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      imask <= 20'h0_0000;
    else if (acc && ADDRESS == OFS_INT_MASK)
      imask <= WRITEDATA[19:0];
  end
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      emask <= 20'h0_0000;
    else if (acc && ADDRESS == OFS_EVT_MASK)
      emask <= WRITEDATA[19:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence req_s;
    req && WAITREQUEST;
  endsequence
  sequence trig_s;
    acc && ADDRESS == OFS_SW_TRIG;
  endsequence

  wait_answer_a: assert property (req_s |=> !WAITREQUEST)
    else $error("Request not answered after one wait cycle");
  wait_single_a: assert property (!WAITREQUEST |=> WAITREQUEST)
    else $error("Wait request low for more than one cycle");
  answer_cause_a: assert property (!WAITREQUEST |-> $past(req))
    else $error("Answer without a request");
  pull_off_a: assert property ((PAD_OE & (PULL_UP_EN | PULL_DOWN_EN)) == '0)
    else $error("Pull enabled on a driven pin");
  pull_excl_a: assert property ((PULL_UP_EN & PULL_DOWN_EN) == '0)
    else $error("Both pulls enabled");
  event_pulse_a: assert property ((EVENT & $past(EVENT)) == '0)
    else $error("Event longer than one cycle");
  event_mask_a: assert property ((EVENT & ~emask) == '0)
    else $error("Event on a masked line");
  irq_hold_a: assert property (|($past(IRQ) & ~IRQ) |-> $past(clr) || $past(clr, 2))
    else $error("Interrupt dropped without a clear");
  sw_event_a: assert property (trig_s |-> ##2 (EVENT & $past(tw, 2)) == $past(tw, 2))
    else $error("Software trigger gave no event");
  sw_irq_a: assert property (trig_s |-> ##2 (IRQ & $past(ti, 2)) == $past(ti, 2))
    else $error("Software trigger gave no interrupt");
endmodule // gpio_event_sva

// *** verification/gpio_event_port_tb.sv ***
// Self-checking bench: bus tasks, pin modes, lock, edges and triggers.
// Assumes the pin partner drives PAD_IN and the checker is bound below.
`timescale 1ns/100ps
module gpio_event_port_tb;
  import gpio_event_pkg::*;
  localparam logic [31:0] RISE_L = 32'h000F_1D00;
  localparam logic [31:0] FALL_L = 32'h0000_0E00;
  localparam logic [31:0] IMASK = 32'h000F_F7FF;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] ADDRESS = 8'h00;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h0000_0000;
  logic [31:0] READDATA;
  logic WAITREQUEST;
  logic [15:0] PAD_IN, PAD_OUT, PAD_OE, PULL_UP_EN, PULL_DOWN_EN;
  logic [15:0] ALT_OUT = 16'h0000;
  logic [47:0] OTHER_PORT_IN = 48'h0000_0000_0000;
  logic [3:0] wake = 4'h0;
  logic [19:0] IRQ, EVENT;
  logic [15:0] ext_val = 16'h0000;
  logic [15:0] ext_en = 16'h0F01;
  logic [31:0] q;
  int miscompares = 0;
  int cmp_count = 0;
  int ev_cnt [20] = '{default: 0};
  logic [7:0] codes [8] = '{ANALOG_INPUT_CODE, FLOATING_INPUT_CODE, PULLDOWN_INPUT_CODE,
    PULLUP_INPUT_CODE, OPENDRAIN_OUTPUT_CODE, PUSHPULL_OUTPUT_CODE, ALT_OPENDRAIN_CODE,
    ALT_PUSHPULL_CODE};

  always #2 CLK = ~CLK;

  gpio_event_port dut (.CLK(CLK), .RST_N(RST_N), .ADDRESS(ADDRESS), .READ(READ),
    .WRITE(WRITE), .BYTEENABLE(4'hF), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .PAD_IN(PAD_IN), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE),
    .PULL_UP_EN(PULL_UP_EN), .PULL_DOWN_EN(PULL_DOWN_EN), .ALT_OUT(ALT_OUT),
    .OTHER_PORT_IN(OTHER_PORT_IN), .LOW_VOLTAGE_DETECT(wake[0]), .CALENDAR_ALARM(wake[1]),
    .SERIAL_BUS_WAKE(wake[2]), .NETWORK_WAKE(wake[3]), .IRQ(IRQ), .EVENT(EVENT));
  pin_partner pins (.clk(CLK), .pad_out(PAD_OUT), .pad_oe(PAD_OE), .pull_up_en(PULL_UP_EN),
    .pull_down_en(PULL_DOWN_EN), .ext_val(ext_val), .ext_en(ext_en), .level(PAD_IN));

  // Event pulses last one cycle, so one sample per edge counts each once
  always @(posedge CLK)
    for (int i = 0; i < 20; i++)
      if (EVENT[i] === 1'b1)
        ev_cnt[i]++;

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    ADDRESS <= a;
    WRITEDATA <= d;
    WRITE <= w;
    READ <= !w;
    // No limit here: a hung answer is ended by the watchdog
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (WAITREQUEST !== 1'b0);
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    // Request edge plus one wait cycle before the answer
    cmp(n, 32'd2);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    cmp(q, e);
  endtask

  task automatic end_sim;
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] c;
    logic v, a, e, oe, o;
    logic [15:0] ov, s, r;
    void'($urandom(32'h85b68363));
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    rd(OFS_MODE3, 32'h0404_0404);
    rd(8'h3C, 32'h0000_0000);
    for (int k = 0; k < 8; k++)
    begin
      c = codes[k];
      v = 1'($urandom);
      a = 1'($urandom);
      e = 1'($urandom);
      ALT_OUT[0] <= a;
      ext_val[0] <= e;
      bus(1'b1, OFS_OUTPUT, {31'h0000_0000, v});
      bus(1'b1, OFS_MODE0, {24'h04_0404, c});
      repeat (6) @(posedge CLK);
      oe = c == OPENDRAIN_OUTPUT_CODE ? !v : c == ALT_OPENDRAIN_CODE ? !a :
           c == PUSHPULL_OUTPUT_CODE || c == ALT_PUSHPULL_CODE;
      o = c == ALT_PUSHPULL_CODE || c == ALT_OPENDRAIN_CODE ? a : v;
      cmp(32'({PAD_OE[0], PAD_OE[0] & PAD_OUT[0], PULL_UP_EN[0], PULL_DOWN_EN[0]}),
          32'({oe, oe & o, c == PULLUP_INPUT_CODE, c == PULLDOWN_INPUT_CODE}));
      rd(OFS_MODE0, {24'h04_0404, c});
      rd(OFS_OUTPUT, {31'h0000_0000, v});
      bus(1'b0, OFS_INPUT, 32'h0000_0000);
      cmp(32'(q[0]), 32'(oe ? o : e));
    end
    bus(1'b1, OFS_LOCK, 32'h0000_0002);
    bus(1'b1, OFS_MODE0, 32'h1010_1010);
    rd(OFS_MODE0, 32'h1010_0410);
    ov = 16'($urandom);
    s = 16'($urandom);
    r = 16'($urandom);
    bus(1'b1, OFS_OUTPUT, {16'h0000, ov});
    bus(1'b1, OFS_SET_RESET, {r, s});
    ov = (ov & ~r) | s;
    rd(OFS_OUTPUT, {16'h0000, ov});
    repeat (2) @(posedge CLK);
    cmp(32'({PAD_OE[3:2], PAD_OUT[3:2]}), 32'({2'b11, ov[3:2]}));
    bus(1'b1, OFS_INT_MASK, IMASK);
    bus(1'b1, OFS_EVT_MASK, 32'h000F_FFFF);
    // Switch line 12 away from its floating pad before any edge is enabled
    bus(1'b1, OFS_SOURCE_SEL, 32'h0100_0000);
    bus(1'b1, OFS_RISE, RISE_L);
    bus(1'b1, OFS_FALL, FALL_L);
    ext_val[11:8] <= 4'hF;
    OTHER_PORT_IN[12] <= 1'b1;
    wake <= 4'hF;
    repeat (8) @(posedge CLK);
    rd(OFS_PENDING, RISE_L & IMASK);
    cmp(32'(IRQ), RISE_L & IMASK);
    bus(1'b1, OFS_PENDING, RISE_L);
    rd(OFS_PENDING, 32'h0000_0000);
    ext_val[11:8] <= 4'h0;
    repeat (8) @(posedge CLK);
    rd(OFS_PENDING, FALL_L & IMASK);
    bus(1'b1, OFS_PENDING, FALL_L);
    bus(1'b1, OFS_SW_TRIG, 32'h0000_0020);
    rd(OFS_PENDING, 32'h0000_0020);
    repeat (4) @(posedge CLK);
    for (int i = 0; i < 20; i++)
      cmp(ev_cnt[i], RISE_L[i] + FALL_L[i] + (i == 5));
    end_sim();
  end
endmodule // gpio_event_port_tb

bind gpio_event_port gpio_event_sva chk (.CLK(CLK), .RST_N(RST_N), .ADDRESS(ADDRESS),
  .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .WAITREQUEST(WAITREQUEST),
  .PAD_OE(PAD_OE), .PULL_UP_EN(PULL_UP_EN), .PULL_DOWN_EN(PULL_DOWN_EN), .IRQ(IRQ),
  .EVENT(EVENT));
